// file: ccr_regs.sv
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_regs
    import ccr_pkg::*;
#(
    parameter int READY_CYCLES = 4  // Settling cycles after enable
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    input  wire logic        cmp_raw,
    input  wire logic        core_ready,
    output ccr_analog_t      analog_ctl,
    output logic             cmp_out,
    output logic             cmp_pad,
    output logic             cmp_pad_oe,
    output logic             irq
);

    // The ready timer is eight bits wide and needs at least one count
    generate
        if (READY_CYCLES < 1 || READY_CYCLES > 255) begin : g_bad_ready
            $error("READY_CYCLES out of range");
        end
    endgenerate

    // All block state
    typedef struct packed {
        ccr_ctrl_t  ctrl;
        logic [1:0] partner_sel;    // Window partner, inert
        ccr_mux_t   mux;
        logic [7:0] ref_level;
        logic [1:0] cond_sel;
        logic       cmp_irq_en;
        logic       cmp_irq_flag;
        logic       sync1;          // Synchroniser first stage
        logic       sync2;
        logic       level;          // Status level, third stage
        logic       level_prev;
        logic [7:0] ready_cnt;
        logic       ready;
        logic       out;            // Delivered output
        logic       pad;
        logic       pad_oe;
        logic       sys_stat;       // Sticky event status
        logic       sys_mask;
        logic [31:0] rdata;
    } ccr_state_t;

    ccr_state_t st_reg;
    ccr_state_t st_next;

    logic        access;
    logic        wr;
    logic [9:0]  idx;
    logic        mapped;
    logic        rise;
    logic        fall;
    logic        event_hit;
    logic        raw_gated;

    // Bus decode; always ready in one access cycle
    assign access = psel && penable;
    assign wr     = access && pwrite && pstrb[0];
    assign idx    = paddr[11:2];

    // Address map check
    always_comb begin
        if (idx == 10'(`CCR_IDX_CTRL_A)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_WINDOW)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_INPUT_SEL)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_REF_LEVEL)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_IRQ_CTRL)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_STATE)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_IRQ_STATUS)) begin
            mapped = 1'b1;
        end else if (idx == 10'(`CCR_IDX_IRQ_MASK)) begin
            mapped = 1'b1;
        end else begin
            mapped = 1'b0;
        end
    end

    // Raw comparator result, ignored while off
    assign raw_gated = st_reg.ctrl.enable & cmp_raw;

    // Edges from synchronised level, current against previous
    assign rise = st_reg.level & ~st_reg.level_prev;
    assign fall = ~st_reg.level & st_reg.level_prev;

    // Single comparator conditions; window unsupported so only these
    always_comb begin
        case (st_reg.cond_sel)
            `CCR_COND_EITHER: event_hit = rise | fall;
            `CCR_COND_FALL:   event_hit = fall;
            `CCR_COND_RISE:   event_hit = rise;
            default:          event_hit = 1'b0;   // Reserved code
        endcase
    end
    // With one instance there is no window, so conditions and the
    // outside match never apply; the field keeps the single meaning.

    // Next-state logic
    always_comb begin
        st_next = st_reg;

        // Three-stage synchroniser on the delivered output
        st_next.sync1      = st_reg.out;
        st_next.sync2      = st_reg.sync1;
        st_next.level      = st_reg.sync2;
        st_next.level_prev = st_reg.level;

        // Ready timer: restarts when disabled
        if (!st_reg.ctrl.enable) begin
            st_next.ready_cnt = 8'h00;
            st_next.ready     = 1'b0;
        end else if (st_reg.ready_cnt != 8'(READY_CYCLES)) begin
            st_next.ready_cnt = st_reg.ready_cnt + 8'h01;
            st_next.ready     = 1'b0;
        end else begin
            st_next.ready     = core_ready;
        end

        // Initial level held until ready, then raw xor invert
        if (st_reg.ready) begin
            st_next.out = raw_gated ^ st_reg.mux.invert;
        end else begin
            st_next.out = st_reg.mux.output_initial_level;
        end

        // Pad follows output while enabled
        st_next.pad_oe = st_reg.ctrl.pad_enable;
        st_next.pad    = st_reg.ctrl.pad_enable & st_reg.out;

        // Flag: write-one clears, a new event wins
        if (wr && idx == 10'(`CCR_IDX_STATE)
                && pwdata[`CCR_ST_FLAG_BIT]) begin
            st_next.cmp_irq_flag = 1'b0;
        end
        if (wr && idx == 10'(`CCR_IDX_IRQ_STATUS) && pwdata[0]) begin
            st_next.sys_stat = 1'b0;
        end
        if (event_hit) begin
            st_next.cmp_irq_flag = 1'b1;
            st_next.sys_stat     = 1'b1;
        end

        // Register writes
        if (wr) begin
            if (idx == 10'(`CCR_IDX_CTRL_A)) begin
                st_next.ctrl.enable         = pwdata[0];
                st_next.ctrl.hysteresis_sel = pwdata[2:1];
                // Reserved profile codes keep the previous value
                if (pwdata[4:3] <= `CCR_PROFILE_MAX) begin
                    st_next.ctrl.current_level = pwdata[4:3];
                end
                st_next.ctrl.pad_enable = pwdata[6];
            end else if (idx == 10'(`CCR_IDX_WINDOW)) begin
                st_next.partner_sel = pwdata[1:0];
            end else if (idx == 10'(`CCR_IDX_INPUT_SEL)) begin
                st_next.mux.invert               = pwdata[7];
                st_next.mux.output_initial_level = pwdata[6];
                st_next.mux.positive_input_sel   = pwdata[5:3];
                st_next.mux.negative_input_sel   = pwdata[2:0];
            end else if (idx == 10'(`CCR_IDX_REF_LEVEL)) begin
                st_next.ref_level = pwdata[7:0];
            end else if (idx == 10'(`CCR_IDX_IRQ_CTRL)) begin
                st_next.cond_sel   = pwdata[5:4];
                st_next.cmp_irq_en = pwdata[0];
            end else if (idx == 10'(`CCR_IDX_IRQ_MASK)) begin
                st_next.sys_mask = pwdata[0];
            end
        end

        // Read data captured in the setup cycle, so prdata is a flop output;
        // hardware-set bits use their next value, which the access cycle
        // holds, so a read still sees the level three edges after the output
        if (psel && !penable && !pwrite) begin
            if (idx == 10'(`CCR_IDX_CTRL_A)) begin
                st_next.rdata = {24'h0, 1'b0, st_reg.ctrl.pad_enable, 1'b0,
                    st_reg.ctrl.current_level, st_reg.ctrl.hysteresis_sel,
                    st_reg.ctrl.enable};
            end else if (idx == 10'(`CCR_IDX_WINDOW)) begin
                st_next.rdata = {30'h0, st_reg.partner_sel};
            end else if (idx == 10'(`CCR_IDX_INPUT_SEL)) begin
                st_next.rdata = {24'h0, st_reg.mux};
            end else if (idx == 10'(`CCR_IDX_REF_LEVEL)) begin
                st_next.rdata = {24'h0, st_reg.ref_level};
            end else if (idx == 10'(`CCR_IDX_IRQ_CTRL)) begin
                st_next.rdata = {26'h0, st_reg.cond_sel, 3'h0,
                    st_reg.cmp_irq_en};
            end else if (idx == 10'(`CCR_IDX_STATE)) begin
                // Window position reads zero while window is off
                st_next.rdata = 32'h0;
                st_next.rdata[`CCR_ST_LEVEL_BIT] = st_next.level;
                st_next.rdata[`CCR_ST_FLAG_BIT]  = st_next.cmp_irq_flag;
            end else if (idx == 10'(`CCR_IDX_IRQ_STATUS)) begin
                st_next.rdata = {31'h0, st_next.sys_stat};
            end else if (idx == 10'(`CCR_IDX_IRQ_MASK)) begin
                st_next.rdata = {31'h0, st_reg.sys_mask};
            end else begin
                st_next.rdata = 32'h0;
            end
        end
    end

    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg                      <= '0;
            st_reg.ctrl                 <= ccr_ctrl_t'(6'(`CCR_RST_CTRL_A));
            st_reg.partner_sel          <= 2'(`CCR_RST_WINDOW);
            st_reg.mux                  <= `CCR_RST_INPUT_SEL;
            st_reg.ref_level            <= `CCR_RST_REF_LEVEL;
            st_reg.cond_sel             <= 2'(`CCR_RST_IRQ_CTRL >> 4);
        end else begin
            st_reg <= st_next;
        end
    end

    // Bus answer: one-cycle access, read data from the capture flop
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;
    // Read data stands from the capture flop for the whole access phase
    assign prdata  = st_reg.rdata;

    // Analog controls: one-hot pin routes, reserved codes route nothing
    always_comb begin
        analog_ctl = '0;
        analog_ctl.enable         = st_reg.ctrl.enable;
        analog_ctl.current_level  = st_reg.ctrl.current_level;
        analog_ctl.hysteresis_sel = st_reg.ctrl.hysteresis_sel;
        analog_ctl.divider_reference_level = st_reg.ref_level;
        case (st_reg.mux.positive_input_sel)
            `CCR_POS_PIN0: analog_ctl.positive_pin_onehot[0] = 1'b1;
            `CCR_POS_PIN3: analog_ctl.positive_pin_onehot[3] = 1'b1;
            `CCR_POS_PIN4: analog_ctl.positive_pin_onehot[4] = 1'b1;
            default:       analog_ctl.positive_pin_onehot    = 5'h00;
        endcase
        if (st_reg.mux.negative_input_sel <= `CCR_NEG_PIN2) begin
            analog_ctl.negative_pin_onehot =
                3'(3'h1 << st_reg.mux.negative_input_sel);
        end else if (st_reg.mux.negative_input_sel == `CCR_NEG_DIVIDER) begin
            analog_ctl.negative_divider = 1'b1;
        end
    end

    // Outputs
    assign cmp_out    = st_reg.out;
    assign cmp_pad    = st_reg.pad;
    assign cmp_pad_oe = st_reg.pad_oe;
    assign irq = (st_reg.cmp_irq_en & st_reg.cmp_irq_flag)
               | (st_reg.sys_mask & st_reg.sys_stat);

endmodule
`default_nettype wire

// file: ccr_defs.svh
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// Register offsets, word index as printed; byte address is four times index
`define CCR_IDX_CTRL_A      3'h0
`define CCR_IDX_WINDOW      3'h1
`define CCR_IDX_INPUT_SEL   3'h2
`define CCR_IDX_REF_LEVEL   3'h5
`define CCR_IDX_IRQ_CTRL    3'h6
`define CCR_IDX_STATE       3'h7
// Own interrupt status and mask, beyond the printed map
`define CCR_IDX_IRQ_STATUS  4'h8
`define CCR_IDX_IRQ_MASK    4'h9
`define CCR_IDX_WIDTH       4

// Reset values
`define CCR_RST_CTRL_A      8'h00
`define CCR_RST_WINDOW      8'h00
`define CCR_RST_INPUT_SEL   8'h00
`define CCR_RST_REF_LEVEL   8'hff
`define CCR_RST_IRQ_CTRL    8'h00

// Write masks (reserved bits read zero)
`define CCR_WMASK_CTRL_A    8'h5f
`define CCR_WMASK_WINDOW    8'h03
`define CCR_WMASK_IRQ_CTRL  8'h31

// Condition codes, single comparator
`define CCR_COND_EITHER     2'h0
`define CCR_COND_FALL       2'h2
`define CCR_COND_RISE       2'h3
// Condition codes, window use
`define CCR_COND_ABOVE      2'h0
`define CCR_COND_INSIDE     2'h1
`define CCR_COND_BELOW      2'h2
`define CCR_COND_OUTSIDE    2'h3

// Positive input codes
`define CCR_POS_PIN0        3'h0
`define CCR_POS_PIN3        3'h3
`define CCR_POS_PIN4        3'h4
// Negative input codes
`define CCR_NEG_PIN2        3'h2
`define CCR_NEG_DIVIDER     3'h4
// Profile codes above this are reserved
`define CCR_PROFILE_MAX     2'h2

// Status layout
`define CCR_ST_FLAG_BIT     0
`define CCR_ST_LEVEL_BIT    4

`endif

// file: ccr_pkg.sv
`default_nettype none
package ccr_pkg;

    // Software-visible control fields
    typedef struct packed {
        logic       pad_enable;      // Output pad enable
        logic [1:0] current_level;   // Current profile
        logic [1:0] hysteresis_sel;  // Hysteresis mode
        logic       enable;          // Comparator on
    } ccr_ctrl_t;

    typedef struct packed {
        logic       invert;                // Output inversion
        logic       output_initial_level;  // Level held until ready
        logic [2:0] positive_input_sel;    // Positive mux
        logic [2:0] negative_input_sel;    // Negative mux
    } ccr_mux_t;

    // Controls carried to the analog core
    typedef struct packed {
        logic       enable;
        logic [1:0] current_level;
        logic [1:0] hysteresis_sel;
        logic [4:0] positive_pin_onehot;   // Bits 0,3,4 used
        logic [2:0] negative_pin_onehot;
        logic       negative_divider;
        logic [7:0] divider_reference_level;
    } ccr_analog_t;

endpackage
`default_nettype wire

// file: ccr_regs_properties.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_properties
    import ccr_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic        cmp_raw,
    input wire logic        core_ready,
    input wire ccr_analog_t analog_ctl,
    input wire logic        cmp_out,
    input wire logic        irq
);
    logic [9:0] idx;     // Word index of the access
    logic       wr_go;   // Write taken this edge
    logic       rd_go;   // Read in its access phase
    logic       inv_sh;  // Copy of the invert control
    assign idx   = paddr[11:2];
    assign wr_go = psel && penable && pwrite && pstrb[0];
    assign rd_go = psel && penable && !pwrite;

    // Invert copy updates on the same edge as the design's own register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inv_sh <= 1'b0;
        end else if (wr_go && idx == 10'h2) begin
            inv_sh <= pwdata[7];
        end
    end

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_enable_taken: assert property (
        wr_go && idx == 10'h0 |=> analog_ctl.enable == $past(pwdata[0]))
        else $error("enable bit not applied");
    a_hyst_taken: assert property (
        wr_go && idx == 10'h0 |=>
        analog_ctl.hysteresis_sel == $past(pwdata[2:1]))
        else $error("hysteresis code not applied");
    a_profile_guard: assert property (
        wr_go && idx == 10'h0 |=> analog_ctl.current_level ==
        ($past(pwdata[4:3]) == 2'h3 ? $past(analog_ctl.current_level)
                                    : $past(pwdata[4:3])))
        else $error("current profile wrong");
    a_ref_taken: assert property (
        wr_go && idx == 10'h5 |=>
        analog_ctl.divider_reference_level == $past(pwdata[7:0]))
        else $error("divider level not applied");
    a_neg_divider: assert property (
        wr_go && idx == 10'h2 |=>
        analog_ctl.negative_divider == ($past(pwdata[2:0]) == 3'h4))
        else $error("divider routing wrong");
    a_neg_route: assert property (
        wr_go && idx == 10'h2 |=> analog_ctl.negative_pin_onehot ==
        ($past(pwdata[2:0]) <= 3'h2 ? 3'(3'h1 << $past(pwdata[2:0]))
                                    : 3'h0))
        else $error("negative pin routing wrong");
    a_pos_route: assert property (
        wr_go && idx == 10'h2 && pwdata[5:3] inside {3'h0, 3'h3, 3'h4}
        |=> analog_ctl.positive_pin_onehot == 5'h1 << $past(pwdata[5:3]))
        else $error("positive pin routing wrong");
    // Only judged once the core has been settled for a while
    a_out_invert: assert property (
        (analog_ctl.enable && core_ready) [*8] |=>
        cmp_out == ($past(cmp_raw) ^ $past(inv_sh)))
        else $error("delivered output wrong");
    a_level_lag: assert property (
        rd_go && idx == 10'h7 |->
        prdata[7:6] == 2'h0 && prdata[4] == $past(cmp_out, 3))
        else $error("status level or window field wrong");

    c_irq: cover property (irq);
    c_refused: cover property (rd_go && pslverr);
    c_inverted: cover property (inv_sh && cmp_out && core_ready);
endmodule
`default_nettype wire

// file: ccr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_core_model
    import ccr_pkg::*;
#(
    parameter int SETTLE = 6  // Cycles from enable to settled
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire ccr_analog_t analog_ctl,
    input  wire logic        pos_above,   // Positive input above negative
    output logic             cmp_raw,
    output logic             core_ready
);
    int   settle_cnt;  // Cycles since the core was switched on, held once it reaches SETTLE
    logic junk;        // Unsettled result flips every cycle

    // Core only settles while enabled; off restarts the wait
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            settle_cnt <= 0;
            junk       <= 1'b0;
        end else begin
            junk       <= ~junk;
            settle_cnt <= !analog_ctl.enable ? 0 :
                          settle_cnt + (settle_cnt < SETTLE ? 1 : 0);
        end
    end
    assign core_ready = analog_ctl.enable && settle_cnt == SETTLE;
    // Result is garbage until settled, so a design must not trust it
    assign cmp_raw = core_ready ? pos_above : junk;
endmodule
`default_nettype wire

// file: ccr_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none
module ccr_regs_tb
    import ccr_pkg::*;
;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0;
    logic        pwrite = 0, pos_above = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic [3:0]  pstrb = 0;
    logic        pready, pslverr, cmp_raw, core_ready;
    logic        cmp_out, cmp_pad, cmp_pad_oe, irq;
    ccr_analog_t analog_ctl;
    logic [32:0] exp_q[$];  // Expected {pslverr, prdata} per read
    int          bad_count = 0, checks_done = 0;

    always #4 pclk = ~pclk;

    ccr_regs #(.READY_CYCLES(2)) u_dut (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb, .pready, .prdata, .pslverr,
        .cmp_raw, .core_ready, .analog_ctl, .cmp_out, .cmp_pad,
        .cmp_pad_oe, .irq);
    ccr_core_model #(.SETTLE(6)) u_core (.pclk, .presetn, .analog_ctl,
        .pos_above, .cmp_raw, .core_ready);

    task automatic end_of_test();
        if (bad_count == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // Case equality, so unknown bits never pass
    task automatic chk(input string nm, input logic [32:0] e,
                       input logic [32:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    // One APB transfer, held until pready under a bound
    task automatic apb(input logic w, input int i, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= 12'(i * 4);
        pwdata  <= d;
        pstrb   <= 4'hf;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) begin
            bad_count++;
            end_of_test();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input int i, input logic [31:0] d);
        apb(1'b1, i, d);
    endtask
    // The note goes in before the bus cycle starts
    task automatic rd(input int i, input logic [32:0] e);
        exp_q.push_back(e);
        apb(1'b0, i, 32'h0);
    endtask
    // Move the analog input, then let the output path settle
    task automatic drive(input logic v);
        @(posedge pclk);
        pos_above <= v;
        repeat (12) @(posedge pclk);
    endtask

    // Pairs each completed read with the oldest note
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            chk("prdata", exp_q.pop_front(), {pslverr, prdata});
        end
    end

    initial begin
        logic [31:0] d;
        logic [7:0]  e, cur;
        int          i;
        logic        f;
        void'($urandom(32'h14bd));
        cur = 8'h0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values, reserved gap and one index past the map
        for (int k = 0; k < 11; k++) begin
            rd(k, {k == 3 || k == 4 || k == 10, k == 5 ? 32'hff : 32'h0});
        end
        // Random writes read back through the reserved-bit masks
        for (int k = 0; k < 15; k++) begin
            i = k % 5 < 3 ? k % 5 : k % 5 + 2;
            d = $urandom();
            e = d[7:0] & (i == 0 ? 8'h5f : i == 1 ? 8'h03 :
                          i == 6 ? 8'h31 : 8'hff);
            if (i == 0 && d[4:3] == 2'h3) begin
                e[4:3] = cur[4:3];
            end
            cur = i == 0 ? e : cur;
            wr(i, d);
            rd(i, {25'h0, e});
        end
        // Initial level must win while the core settles
        wr(0, 32'h0);
        wr(2, 32'h40);
        wr(0, 32'h41);
        @(negedge pclk);
        chk("init level", 33'h1, {32'h0, cmp_out});
        for (int k = 0; k < 4; k++) begin
            wr(2, {24'h0, k[1], 7'h0});
            drive(k[0]);
            @(negedge pclk);
            chk("output", {32'h0, k[0] ^ k[1]}, {32'h0, cmp_out});
            chk("pad", {31'h0, 1'b1, k[0] ^ k[1]}, {31'h0, cmp_pad_oe, cmp_pad});
        end
        wr(0, 32'h01);
        // Pad enable output is registered one edge after the control bit
        @(posedge pclk);
        @(negedge pclk);
        chk("pad off", 33'h0, {32'h0, cmp_pad_oe});
        // Every condition code over one rise and one fall
        wr(2, 32'h0);
        for (int k = 0; k < 4; k++) begin
            f = k != 1;
            drive(1'b0);
            wr(6, {26'h0, k[1:0], 4'h0});
            wr(7, 32'h1);
            wr(8, 32'h1);
            rd(7, 33'h0);
            drive(1'b1);
            rd(7, {29'h1, 3'h0, k == 0 || k == 3});
            drive(1'b0);
            rd(7, {32'h0, f});
            rd(8, {32'h0, f});
            wr(6, {26'h0, k[1:0], 4'h1});
            @(negedge pclk);
            chk("irq", {32'h0, f}, {32'h0, irq});
            wr(7, 32'h0);
            rd(7, {32'h0, f});
        end
        // Sticky status seen through its own mask
        wr(6, 32'h0);
        wr(7, 32'h1);
        wr(9, 32'h1);
        @(negedge pclk);
        chk("irq unmasked", 33'h1, {32'h0, irq});
        wr(9, 32'h0);
        @(negedge pclk);
        chk("irq masked", 33'h0, {32'h0, irq});
        wr(9, 32'h1);
        wr(8, 32'h1);
        @(negedge pclk);
        chk("irq cleared", 33'h0, {32'h0, irq});
        repeat (3) @(posedge pclk);
        chk("pending reads", 33'h0, 33'(exp_q.size()));
        end_of_test();
    end
endmodule

bind ccr_regs ccr_regs_properties u_props (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pslverr,
    .cmp_raw, .core_ready, .analog_ctl, .cmp_out, .irq);
`default_nettype wire
